// ==== core/edge_event_detect.sv ====
// per-source rising and falling edge detector with enable masks
`timescale 1ns/1ps
`include "ulpi_intr_defs.svh"
module edge_event_detect (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // edge group
   edge_if.detector port
);
   ulpi_intr_pkg::src_vec_t prev_ff;
   ulpi_intr_pkg::src_vec_t nxt_prev;

   // =====================================================================
   // edge detection
   // prev keeps tracking while masked, so enabling later gives no false edge
   always_comb begin
      nxt_prev = port.level;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prev_ff <= `LATCH_RESET;
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   assign port.evt = (port.level & ~prev_ff & port.rise_en)
                   | (~port.level & prev_ff & port.fall_en);
   assign port.powered = port.rise_en | port.fall_en;

   // =====================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_fall_needs_enable: assert property ((port.evt & ~port.level & ~port.fall_en) == 5'h00)
      else $error("falling event on a source whose falling enable is off");
   a_rise_needs_enable: assert property ((port.evt & port.level & ~port.rise_en) == 5'h00)
      else $error("rising event on a source whose rising enable is off");
   a_unpowered_quiet: assert property ((port.evt & ~port.powered) == 5'h00)
      else $error("event from a powered-down detector");
endmodule // edge_event_detect

// ==== core/two_flop_sync.sv ====
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module two_flop_sync #(
   parameter int WIDTH = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] nxt_stage1;
   logic [WIDTH-1:0] nxt_stage2;

   // =====================================================================
   // two stages, the first read only by the second
   always_comb begin
      nxt_stage1 = async_in;
      nxt_stage2 = stage1_ff;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= nxt_stage2;
      end
   end

   assign sync_out = stage2_ff;
endmodule // two_flop_sync

// ==== core/ulpi_interrupt_latch_debug_regs.sv ====
// interrupt event latch, line level monitor and spare test byte of the register space
// How it works
// - an enabled change on a status source sets its latch bit
// - reading the latch register clears all its bits
// - entering low-power mode clears the latch, keeping only events of the entry cycle
// - entering either serial mode clears the latch, whatever the clock hold setting
// - a source with both edge enables off may power its detector down
// - an event during the latch read shows in the read data, latch stays zero
// - bits: detach 0, supply 1, session valid 2, session over 3, id 4; 7:5 zero
// - detach bit counts only in host mode, both pulldowns on
// - monitor at 15h reads live line levels in bits 1:0, rest zero
// - spare byte resets to 00h, read 16h-18h, write 16h, set 17h, clear 18h
// - each edge counts only when its rising or falling enable bit is one
`timescale 1ns/1ps
`include "ulpi_intr_defs.svh"
module ulpi_interrupt_latch_debug_regs (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_hit,
   // status sources from the analog side
   input wire logic downstream_detach,
   input wire logic supply_valid_flag,
   input wire logic session_valid,
   input wire logic session_over,
   input wire logic id_pin_grounded,
   input wire logic line_level_bit0,
   input wire logic line_level_bit1,
   // edge enables and pulldowns from neighbouring registers
   input wire logic [4:0] rising_edge_enable_reg,
   input wire logic [4:0] falling_edge_enable_reg,
   input wire logic plus_line_pulldown,
   input wire logic minus_line_pulldown,
   // mode entry pulses
   input wire logic low_power_entry,
   input wire logic serial_mode_entry,
   // status out
   output logic latch_pending,
   output logic [4:0] detect_power_en
);
   logic [6:0] sync_vec;
   ulpi_intr_pkg::src_vec_t status_sync;
   ulpi_intr_pkg::line_t line_sync;
   ulpi_intr_pkg::src_vec_t set_vec;
   logic host_mode;
   logic rd_latch;
   logic mode_clear;
   ulpi_intr_pkg::wr_op_t wr_op;

   ulpi_intr_pkg::src_vec_t latch_ff;
   ulpi_intr_pkg::src_vec_t nxt_latch;
   ulpi_intr_pkg::byte_t spare_ff;
   ulpi_intr_pkg::byte_t nxt_spare;
   ulpi_intr_pkg::byte_t rdata_ff;
   ulpi_intr_pkg::byte_t nxt_rdata;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic hit_ff;
   logic nxt_hit;
   logic pending_ff;
   logic nxt_pending;
   ulpi_intr_pkg::src_vec_t power_ff;
   ulpi_intr_pkg::src_vec_t nxt_power;

   // ======================================================================
   // synchronise analog levels
   // line levels ride with the status bits, so both see the same delay
   two_flop_sync #(
      .WIDTH(7)
   ) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in({line_level_bit1, line_level_bit0, id_pin_grounded, session_over,
                 session_valid, supply_valid_flag, downstream_detach}),
      .sync_out(sync_vec)
   );

   assign status_sync = sync_vec[4:0];
   assign line_sync = sync_vec[6:5];

   // ======================================================================
   // edge detection
   edge_if ev ();

   assign ev.level = status_sync;
   assign ev.rise_en = rising_edge_enable_reg;
   assign ev.fall_en = falling_edge_enable_reg;

   edge_event_detect u_edge (
      .clk(clk),
      .reset(reset),
      .port(ev.detector)
   );

   // detach means nothing unless both pulldowns are on
   assign host_mode = plus_line_pulldown & minus_line_pulldown;
   assign set_vec = ev.evt & {4'hf, host_mode};

   // ======================================================================
   // access decode
   // only a latch read steals same-cycle events; other reads leave it alone
   assign rd_latch = reg_rd && (reg_addr == `LATCH_ADDR);
   assign mode_clear = low_power_entry | serial_mode_entry;

   always_comb begin
      wr_op = ulpi_intr_pkg::wr_none;
      if (reg_wr) begin
         case (reg_addr)
            `SPARE_ADDR: wr_op = ulpi_intr_pkg::wr_store;
            `SPARE_SET_ADDR: wr_op = ulpi_intr_pkg::wr_set;
            `SPARE_CLR_ADDR: wr_op = ulpi_intr_pkg::wr_clear;
            default: wr_op = ulpi_intr_pkg::wr_none;
         endcase
      end
   end

   // ======================================================================
   // interrupt event latch
   // a read takes the event into the data instead, so nothing is lost
   always_comb begin
      nxt_latch = latch_ff;
      if (rd_latch) begin
         nxt_latch = `LATCH_RESET;
      end else begin
         if (mode_clear) begin
            nxt_latch = `LATCH_RESET;
         end
         // set beats a mode clear, so an edge in the entry cycle is kept
         nxt_latch = nxt_latch | set_vec;
      end
      nxt_pending = |nxt_latch;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         latch_ff <= `LATCH_RESET;
         pending_ff <= 1'b0;
      end else begin
         latch_ff <= nxt_latch;
         pending_ff <= nxt_pending;
      end
   end

   // ======================================================================
   // spare test byte, touches nothing else
   // set and clear act on the written ones only
   always_comb begin
      nxt_spare = spare_ff;
      case (wr_op)
         ulpi_intr_pkg::wr_store: nxt_spare = reg_wdata;
         ulpi_intr_pkg::wr_set: nxt_spare = spare_ff | reg_wdata;
         ulpi_intr_pkg::wr_clear: nxt_spare = spare_ff & ~reg_wdata;
         default: nxt_spare = spare_ff;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         spare_ff <= `SPARE_RESET;
      end else begin
         spare_ff <= nxt_spare;
      end
   end

   // ======================================================================
   // read data
   // 17h and 18h read the spare byte too; unknown places read 00h, no hit
   always_comb begin
      nxt_rdata = rdata_ff;
      nxt_rvalid = reg_rd;
      nxt_hit = hit_ff;
      if (reg_rd) begin
         nxt_hit = 1'b1;
         case (reg_addr)
            `LATCH_ADDR: nxt_rdata = {3'h0, latch_ff | set_vec};
            `MONITOR_ADDR: nxt_rdata = {6'h00, line_sync};
            `SPARE_ADDR,
            `SPARE_SET_ADDR,
            `SPARE_CLR_ADDR: nxt_rdata = spare_ff;
            default: begin
               nxt_rdata = `RDATA_RESET;
               nxt_hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_ff <= `RDATA_RESET;
         rvalid_ff <= 1'b0;
         hit_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         hit_ff <= nxt_hit;
      end
   end

   // ======================================================================
   // detector power enables
   // registered so the pin comes straight from a flop, one cycle late
   always_comb begin
      nxt_power = ev.powered;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         power_ff <= `LATCH_RESET;
      end else begin
         power_ff <= nxt_power;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign reg_hit = hit_ff;
   assign latch_pending = pending_ff;
   assign detect_power_en = power_ff;

   // ======================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_latch_read;
      rd_latch;
   endsequence

   sequence s_quiet_mode_clear;
      mode_clear && !rd_latch && (set_vec == 5'h00);
   endsequence

   sequence s_spare_write(ulpi_intr_pkg::wr_op_t op);
      wr_op == op;
   endsequence

   sequence s_spare_read;
      reg_rd && (reg_addr >= `SPARE_ADDR) && (reg_addr <= `SPARE_CLR_ADDR);
   endsequence

   // latch: reads, collisions and events
   a_latch_read_clear: assert property (s_latch_read |=> latch_ff == 5'h00)
      else $error("latch not zero after a latch read");
   a_read_shows_event: assert property (s_latch_read |=> (reg_rvalid && reg_hit
      && reg_rdata == {3'h0, $past(latch_ff) | $past(set_vec)}))
      else $error("latch read data misses a same-cycle event");
   a_event_sets_bit: assert property ((set_vec != 5'h00) && !rd_latch
      |=> ((latch_ff & $past(set_vec)) == $past(set_vec)) && latch_pending)
      else $error("unmasked event did not set its latch bit");
   a_collision_zero: assert property (s_latch_read && (set_vec != 5'h00)
      |=> (latch_ff & $past(set_vec)) == 5'h00)
      else $error("latch bit survived a read collision");
   a_latch_holds: assert property (!rd_latch && !mode_clear && (set_vec == 5'h00)
      |=> $stable(latch_ff))
      else $error("latch changed without an event or a clear");
   a_pending_follows: assert property (latch_pending == (latch_ff != 5'h00))
      else $error("pending flag disagrees with the latch");

   // mode entry clears, but an event in that cycle survives
   a_mode_clear: assert property (s_quiet_mode_clear |=> !latch_pending)
      else $error("latch not cleared on low-power or serial entry");
   a_mode_keeps_set: assert property (mode_clear && !rd_latch
      |=> latch_ff == $past(set_vec))
      else $error("latch after a mode clear is not just the new events");
   a_detach_host_only: assert property (!host_mode |-> !set_vec[`BIT_DETACH])
      else $error("detach event outside host mode");

   // latch reserved bits, monitor read data and detector power enables
   a_reserved_zero: assert property (rd_latch |=> reg_rdata[7:5] == 3'h0)
      else $error("latch reserved bits read nonzero");
   a_monitor_live: assert property (reg_rd && reg_addr == `MONITOR_ADDR
      |=> reg_rdata == {6'h00, $past(line_sync)})
      else $error("monitor read differs from line levels");
   a_power_follows: assert property (1'b1
      |=> detect_power_en == ($past(rising_edge_enable_reg) | $past(falling_edge_enable_reg)))
      else $error("detector power enables do not follow the edge enables");

   // spare byte
   a_spare_set: assert property (s_spare_write(ulpi_intr_pkg::wr_set)
      |=> spare_ff == ($past(spare_ff) | $past(reg_wdata)))
      else $error("spare set did not OR data in");
   a_spare_clear: assert property (s_spare_write(ulpi_intr_pkg::wr_clear)
      |=> spare_ff == ($past(spare_ff) & ~$past(reg_wdata)))
      else $error("spare clear did not zero the written ones");
   a_spare_store: assert property (s_spare_write(ulpi_intr_pkg::wr_store)
      |=> spare_ff == $past(reg_wdata))
      else $error("spare store did not take the written byte");
   a_spare_read: assert property (s_spare_read
      |=> reg_hit && reg_rdata == $past(spare_ff))
      else $error("spare byte read back wrong");
endmodule // ulpi_interrupt_latch_debug_regs

// ==== inc/edge_if.sv ====
// edge detection group between the latch block and its detector
`timescale 1ns/1ps
interface edge_if;
   ulpi_intr_pkg::src_vec_t level;
   ulpi_intr_pkg::src_vec_t rise_en;
   ulpi_intr_pkg::src_vec_t fall_en;
   ulpi_intr_pkg::src_vec_t evt;
   ulpi_intr_pkg::src_vec_t powered;
   modport detector (
      input level,
      input rise_en,
      input fall_en,
      output evt,
      output powered
   );
   modport owner (
      output level,
      output rise_en,
      output fall_en,
      input evt,
      input powered
   );
endinterface

// ==== inc/ulpi_intr_defs.svh ====
// register offsets, field positions and reset values of the interrupt latch block
`ifndef ULPI_INTR_DEFS_SVH
`define ULPI_INTR_DEFS_SVH

// ======================================================================
// register offsets
`define LATCH_ADDR 6'h14
`define MONITOR_ADDR 6'h15
`define SPARE_ADDR 6'h16
`define SPARE_SET_ADDR 6'h17
`define SPARE_CLR_ADDR 6'h18

// ======================================================================
// latch field positions
`define BIT_DETACH 0
`define BIT_SUPPLY 1
`define BIT_SESS_VALID 2
`define BIT_SESS_OVER 3
`define BIT_ID_GND 4
`define NUM_SOURCES 5

// ======================================================================
// reset values
`define LATCH_RESET 5'h00
`define MONITOR_RESET 2'h0
`define SPARE_RESET 8'h00
`define RDATA_RESET 8'h00

`endif

// ==== inc/ulpi_intr_pkg.sv ====
// types shared by the interrupt latch block
package ulpi_intr_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [5:0] addr_t;
   typedef logic [4:0] src_vec_t;
   typedef logic [1:0] line_t;
   // gray-coded register write kinds
   typedef enum logic [1:0] {
      wr_none = 2'h0,
      wr_store = 2'h1,
      wr_set = 2'h3,
      wr_clear = 2'h2
   } wr_op_t;
endpackage

// ==== test/link_model.sv ====
// link side model issuing single-byte register reads and writes
`timescale 1ns/1ps
module link_model (
   // clock
   input wire logic clk,
   // register port towards the device
   output logic [5:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_hit
);
   // idle cycles before each request, so the link can be slow
   int pace = 0;
   initial begin
      reg_addr = 6'h3f;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // ==========================================================
   // requests; idle bus shows inverted leftovers, never the old request
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      repeat (pace) @(negedge clk);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // reads happen only when asked; latch polling is optional for the link
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic h,
      output logic ok);
      repeat (pace) @(negedge clk);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = 1'b0;
      d = 8'h00;
      h = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            h = reg_hit;
            ok = 1'b1;
         end else begin
            @(negedge clk);
         end
      end
   endtask
endmodule // link_model

// ==== test/tb_ulpi_interrupt_latch_debug_regs.sv ====
// self-checking bench for the interrupt latch, line monitor and spare byte
`timescale 1ns/1ps
module tb_ulpi_interrupt_latch_debug_regs;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d1, d2, sp, ex;
   logic reg_rd, reg_wr, reg_rvalid, reg_hit, latch_pending;
   logic [4:0] src = 5'h00, ren = 5'h00, fen = 5'h00, old, detect_power_en;
   logic [1:0] lines = 2'h0;
   logic host = 1'b0, low_power = 1'b0, serial = 1'b0;
   int bad_count = 0, total_checks = 0;
   always #5 clk = ~clk;
   // ==========================================================
   // device and link
   ulpi_interrupt_latch_debug_regs i_ulpi_interrupt_latch_debug_regs (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_hit(reg_hit), .downstream_detach(src[0]), .supply_valid_flag(src[1]),
      .session_valid(src[2]), .session_over(src[3]), .id_pin_grounded(src[4]),
      .line_level_bit0(lines[0]), .line_level_bit1(lines[1]),
      .rising_edge_enable_reg(ren), .falling_edge_enable_reg(fen),
      .plus_line_pulldown(host), .minus_line_pulldown(host),
      .low_power_entry(low_power), .serial_mode_entry(serial),
      .latch_pending(latch_pending), .detect_power_en(detect_power_en));
   link_model i_link_model (
      .clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_hit(reg_hit));
   // ==========================================================
   // expectations and checks
   function automatic logic [7:0] exp_ev(input logic [4:0] o, input logic [4:0] n);
      logic [4:0] ev;
      ev = ((~o & n) & ren) | ((o & ~n) & fen);
      if (!host) begin
         ev[0] = 1'b0;
      end
      return {3'h0, ev};
   endfunction
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic h);
      logic ok;
      i_link_model.rd(a, d, h, ok);
      if (!ok) begin
         bad_count++;
         end_of_test();
      end
   endtask
   task automatic rdc(input string what, input logic [5:0] a, input logic [7:0] e,
      input logic eh);
      logic [7:0] d;
      logic h;
      rd(a, d, h);
      chk(what, e, d);
      chk("hit", {7'h0, eh}, {7'h0, h});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // ==========================================================
   // sequence
   initial begin
      logic h;
      void'($urandom(32'he8d5));
      cyc(12);
      reset = 1'b0;
      rdc("latch", 6'h14, 8'h00, 1'b1);
      rdc("monitor", 6'h15, 8'h00, 1'b1);
      rdc("spare", 6'h16, 8'h00, 1'b1);
      rdc("unmapped", 6'h3f, 8'h00, 1'b0);
      for (int i = 0; i < 24; i++) begin
         i_link_model.pace = $urandom % 3;
         ren = 5'($urandom);
         fen = 5'($urandom);
         host = 1'($urandom);
         cyc(2);
         chk("power", {3'h0, ren | fen}, {3'h0, detect_power_en});
         old = src;
         // id pullup counted as long on, so the id level is already valid
         src = (i == 0) ? 5'h1f : 5'($urandom);
         ex = exp_ev(old, src);
         cyc(6);
         chk("pending", {7'h0, |ex}, {7'h0, latch_pending});
         rdc("latch", 6'h14, ex, 1'b1);
         rdc("cleared", 6'h14, 8'h00, 1'b1);
      end
      // both edges on keeps every change visible
      ren = 5'h1f;
      fen = 5'h1f;
      host = 1'b1;
      // change lands at varying distance from a latch read
      for (int k = 0; k < 5; k++) begin
         old = src;
         src = ~src;
         ex = exp_ev(old, src);
         cyc(k);
         rd(6'h14, d1, h);
         cyc(6);
         rd(6'h14, d2, h);
         chk("union", ex, d1 | d2);
         chk("overlap", 8'h00, d1 & d2);
      end
      for (int m = 0; m < 2; m++) begin
         src = ~src;
         cyc(6);
         chk("pending", 8'h01, {7'h0, latch_pending});
         low_power = (m == 0);
         serial = (m == 1);
         cyc(1);
         low_power = 1'b0;
         serial = 1'b0;
         cyc(2);
         chk("pending", 8'h00, {7'h0, latch_pending});
         rdc("latch", 6'h14, 8'h00, 1'b1);
      end
      for (int i = 0; i < 4; i++) begin
         lines = 2'(i);
         cyc(4);
         rdc("monitor", 6'h15, {6'h00, lines}, 1'b1);
      end
      sp = 8'h00;
      for (int i = 0; i < 12; i++) begin
         d1 = 8'($urandom);
         i_link_model.wr(6'h16 + 6'(i % 3), d1);
         sp = (i % 3 == 0) ? d1 : (i % 3 == 1) ? (sp | d1) : (sp & ~d1);
         rdc("spare", 6'h16 + 6'($urandom % 3), sp, 1'b1);
      end
      // read-only places refuse writes
      i_link_model.wr(6'h14, 8'hff);
      i_link_model.wr(6'h15, 8'hff);
      rdc("latch", 6'h14, 8'h00, 1'b1);
      rdc("monitor", 6'h15, {6'h00, lines}, 1'b1);
      rdc("spare", 6'h16, sp, 1'b1);
      // a second reset returns the spare byte to zero
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      rdc("spare", 6'h16, 8'h00, 1'b1);
      end_of_test();
   end
endmodule // tb_ulpi_interrupt_latch_debug_regs
